// file: core/ahrs_pkg.sv
// Package: register map, health word layout and timing for the AHRS readout block
package ahrs_pkg;
   // Printed offsets are register indices; byte address is index times four
   localparam logic [7:0] IDX_MAG_OFF_X = 8'h18;
   localparam logic [7:0] IDX_MAG_OFF_Y = 8'h19;
   localparam logic [7:0] IDX_MAG_OFF_Z = 8'h1a;
   localparam logic [7:0] IDX_HEALTH = 8'h55;
   localparam logic [7:0] IDX_RATE_XY = 8'h56;
   localparam logic [7:0] IDX_RATE_Z = 8'h57;
   localparam logic [7:0] IDX_RATE_TIME = 8'h58;
   localparam logic [7:0] IDX_ACC_XY = 8'h59;
   localparam logic [7:0] IDX_ACC_Z = 8'h5a;
   localparam logic [7:0] IDX_ACC_TIME = 8'h5b;
   localparam logic [7:0] IDX_FLD_XY = 8'h5c;
   localparam logic [7:0] IDX_FLD_Z = 8'h5d;
   localparam logic [7:0] IDX_FLD_TIME = 8'h5e;
   // Health word field positions
   localparam int HL_USED_LSB = 26;
   localparam int HL_PREC_LSB = 16;
   localparam int HL_VIS_LSB = 10;
   localparam int HL_OVF_BIT = 8;
   localparam int HL_FNORM_BIT = 5;
   localparam int HL_GNORM_BIT = 4;
   localparam int HL_ACC_INIT_BIT = 3;
   localparam int HL_RATE_INIT_BIT = 2;
   localparam int HL_FLD_INIT_BIT = 1;
   localparam int HL_RXTO_BIT = 0;
   localparam int HL_RES_HI_BIT = 9;
   localparam int HL_RES_LO_LSB = 6;
   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // Receiver timeout: two seconds at 100 MHz
   localparam longint RXTO_MS = 2000;
   localparam longint CLK_HZ = 100000000;
   localparam longint RXTO_CYCLES = (RXTO_MS * CLK_HZ) / 1000;
endpackage

// file: core/ahrs_regs.sv
// AHRS health, hard-iron offset and raw sensor register block with APB slave
// Operation
// R01: Three RW float hard-iron offset registers
// R02: Health bits 31:26 satellites used count
// R03: Health bits 25:16 precision times ten
// R04: Health bits 15:10 satellites visible count
// R05: Set overrun flag when broadcast exceeds baud
// R06: Set field norm fault flag
// R07: Set gravity norm fault flag
// R08: Separate start-up failure bits per sensor
// R09: Receiver timeout after two seconds, packet clears
// R10: Health bits 9, 7:6 reserved zero
// R11: Rate xy: x upper, y lower
// R12: Rate z upper half, lower reserved
// R13: Acceleration xy: x upper, y lower
// R14: Acceleration z upper half, lower reserved
// R15: Field xy: x upper, y lower
// R16: Field z upper half, lower reserved
// R17: Rate sample timestamp float register
// R18: Acceleration sample timestamp float register
// R19: Field sample timestamp float register
// R20: Sample and timestamp update together
// R21: Writes to read-only registers ignored
`timescale 1ns/1ps
module ahrs_regs #(
   parameter longint RXTO_LIMIT = ahrs_pkg::RXTO_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [5:0] satellites_used_count,
   input wire logic [9:0] horizontal_precision_field,
   input wire logic [5:0] satellites_visible_count,
   input wire logic receiver_fix_valid,
   input wire logic receiver_packet_stb,
   input wire logic tx_rate_overrun_flag,
   input wire logic field_norm_fault_flag,
   input wire logic gravity_norm_fault_flag,
   input wire logic accel_init_fail,
   input wire logic rate_init_fail,
   input wire logic field_init_fail,
   input wire logic rate_sample_stb,
   input wire logic [15:0] rate_x,
   input wire logic [15:0] rate_y,
   input wire logic [15:0] rate_z,
   input wire logic [31:0] rate_time,
   input wire logic accel_sample_stb,
   input wire logic [15:0] accel_x,
   input wire logic [15:0] accel_y,
   input wire logic [15:0] accel_z,
   input wire logic [31:0] accel_time,
   input wire logic field_sample_stb,
   input wire logic [15:0] field_x,
   input wire logic [15:0] field_y,
   input wire logic [15:0] field_z,
   input wire logic [31:0] field_time,
   output logic [31:0] magnetic_offset_x,
   output logic [31:0] magnetic_offset_y,
   output logic [31:0] magnetic_offset_z,
   output logic receiver_timeout_flag
);
   import ahrs_pkg::*;

   localparam logic [31:0] RXTO_LAST = 32'(RXTO_LIMIT - 1);

   // Register index from byte address; word aligned only
   function automatic logic [7:0] reg_index(input logic [11:0] addr);
      reg_index = addr[9:2];
   endfunction

   // Merge write data into a word under byte strobes
   function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      strb_merge = r;
   endfunction

   // Aligned and inside the index window; an erroring address must never reach a register
   function automatic logic addr_ok(input logic [11:0] addr);
      addr_ok = (addr[1:0] == 2'b00) && (addr[11:10] == 2'b00);
   endfunction

   logic [31:0] mag_off_q [3];
   logic [31:0] health_q;
   logic [31:0] health_d;
   logic [31:0] rate_xy_q;
   logic [31:0] rate_z_q;
   logic [31:0] rate_time_q;
   logic [31:0] acc_xy_q;
   logic [31:0] acc_z_q;
   logic [31:0] acc_time_q;
   logic [31:0] fld_xy_q;
   logic [31:0] fld_z_q;
   logic [31:0] fld_time_q;
   logic [31:0] rxto_cnt_q;
   logic rxto_q;
   logic [31:0] prdata_d;
   logic pslverr_d;
   logic access;
   logic [7:0] idx;
   logic wr_ok;

   // Setup detect, index, and a write qualifier that no misaligned or out-of-window address passes
   assign access = psel & ~penable;
   assign idx = reg_index(paddr);
   assign wr_ok = psel & penable & pready & pwrite & addr_ok(paddr);

   // Hard-iron offsets: the only host-writable words
   generate
      for (genvar a = 0; a < 3; a++) begin : g_off
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mag_off_q[a] <= RST_WORD;
            end else if (wr_ok && idx == IDX_MAG_OFF_X + 8'(a)) begin
               mag_off_q[a] <= strb_merge(mag_off_q[a], pwdata, pstrb); // R01
            end
         end
      end
   endgenerate

   assign magnetic_offset_x = mag_off_q[0];
   assign magnetic_offset_y = mag_off_q[1];
   assign magnetic_offset_z = mag_off_q[2];

   // Receiver silence counter; a packet restarts it and clears the flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxto_cnt_q <= 32'h0000_0000;
         rxto_q <= 1'b0;
      end else if (receiver_packet_stb) begin
         rxto_cnt_q <= 32'h0000_0000; // R09
         rxto_q <= 1'b0; // R09
      end else if (rxto_cnt_q >= RXTO_LAST) begin
         rxto_q <= 1'b1; // R09
      end else begin
         rxto_cnt_q <= rxto_cnt_q + 32'h0000_0001;
      end
   end

   assign receiver_timeout_flag = rxto_q;

   // Next health word; satellite fields hold their last report while no fix is valid
   always_comb begin
      health_d = health_q;
      if (receiver_fix_valid) begin
         health_d[HL_USED_LSB +: 6] = satellites_used_count; // R02
         health_d[HL_PREC_LSB +: 10] = horizontal_precision_field; // R03
         health_d[HL_VIS_LSB +: 6] = satellites_visible_count; // R04
      end
      health_d[HL_RES_HI_BIT] = 1'b0; // R10
      health_d[HL_RES_LO_LSB +: 2] = 2'b00; // R10
      health_d[HL_OVF_BIT] = tx_rate_overrun_flag; // R05
      health_d[HL_FNORM_BIT] = field_norm_fault_flag; // R06
      health_d[HL_GNORM_BIT] = gravity_norm_fault_flag; // R07
      health_d[HL_ACC_INIT_BIT] = accel_init_fail; // R08
      health_d[HL_RATE_INIT_BIT] = rate_init_fail; // R08
      health_d[HL_FLD_INIT_BIT] = field_init_fail; // R08
      health_d[HL_RXTO_BIT] = rxto_q; // R09
   end

   // Health word register; flags lag their inputs by one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         health_q <= RST_WORD;
      end else begin
         health_q <= health_d;
      end
   end

   // Rate sample and timestamp captured on one strobe so they never mismatch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_xy_q <= RST_WORD;
         rate_z_q <= RST_WORD;
         rate_time_q <= RST_WORD;
      end else if (rate_sample_stb) begin
         rate_xy_q <= {rate_x, rate_y}; // R11 R20
         rate_z_q <= {rate_z, 16'h0000}; // R12
         rate_time_q <= rate_time; // R17 R20
      end
   end

   // Acceleration sample and timestamp
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_xy_q <= RST_WORD;
         acc_z_q <= RST_WORD;
         acc_time_q <= RST_WORD;
      end else if (accel_sample_stb) begin
         acc_xy_q <= {accel_x, accel_y}; // R13 R20
         acc_z_q <= {accel_z, 16'h0000}; // R14
         acc_time_q <= accel_time; // R18 R20
      end
   end

   // Magnetic field sample and timestamp
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fld_xy_q <= RST_WORD;
         fld_z_q <= RST_WORD;
         fld_time_q <= RST_WORD;
      end else if (field_sample_stb) begin
         fld_xy_q <= {field_x, field_y}; // R15 R20
         fld_z_q <= {field_z, 16'h0000}; // R16
         fld_time_q <= field_time; // R19 R20
      end
   end

   // Read mux; writes to read-only words are dropped without error
   always_comb begin
      prdata_d = 32'h0000_0000;
      pslverr_d = 1'b0;
      case (idx)
         IDX_MAG_OFF_X: prdata_d = mag_off_q[0];
         IDX_MAG_OFF_Y: prdata_d = mag_off_q[1];
         IDX_MAG_OFF_Z: prdata_d = mag_off_q[2];
         IDX_HEALTH: prdata_d = health_q;
         IDX_RATE_XY: prdata_d = rate_xy_q;
         IDX_RATE_Z: prdata_d = rate_z_q;
         IDX_RATE_TIME: prdata_d = rate_time_q;
         IDX_ACC_XY: prdata_d = acc_xy_q;
         IDX_ACC_Z: prdata_d = acc_z_q;
         IDX_ACC_TIME: prdata_d = acc_time_q;
         IDX_FLD_XY: prdata_d = fld_xy_q;
         IDX_FLD_Z: prdata_d = fld_z_q;
         IDX_FLD_TIME: prdata_d = fld_time_q;
         default: pslverr_d = 1'b1; // Unmapped index; misaligned addresses are caught by the addr_ok check below
      endcase
      if (!addr_ok(paddr)) begin
         pslverr_d = 1'b1;
      end
      if (pslverr_d) begin
         prdata_d = 32'h0000_0000; // Error answers carry no data
      end
      if (pwrite) begin
         prdata_d = 32'h0000_0000; // R21
      end
   end

   // APB answer registered in setup, so access phase always has one wait-free cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= access;
         prdata <= access ? prdata_d : 32'h0000_0000;
         pslverr <= access & pslverr_d;
      end
   end
endmodule

// file: bench/ahrs_sensor_model.sv
// Sensor front-end model: one strobed sample with its timestamp
`timescale 1ns/1ps
module ahrs_sensor_model (
   input wire logic pclk,
   input wire logic fire,
   input wire logic [15:0] pat,
   output logic stb = 1'b0,
   output logic [15:0] x = 16'h0000,
   output logic [15:0] y = 16'h0000,
   output logic [15:0] z = 16'h0000,
   output logic [31:0] t = 32'h0000_0000
);
   // Sample and time move at one edge; lines toggle between strobes so stale data shows
   always @(posedge pclk) begin
      stb <= fire;
      x <= fire ? pat : ~x;
      y <= fire ? ~pat : ~y;
      z <= fire ? pat ^ 16'h8001 : ~z;
      t <= fire ? {~pat, pat} : ~t;
   end
endmodule

// file: bench/ahrs_regs_sva.sv
// Checker: APB answer, offset register and receiver timeout
`timescale 1ns/1ps
module ahrs_regs_sva #(parameter longint RXTO_LIMIT = 50) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic receiver_packet_stb,
   input wire logic [31:0] magnetic_offset_x,
   input wire logic receiver_timeout_flag
);
   longint quiet_q;
   logic setup;
   assign setup = psel && !penable;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Idle cycles since the last receiver packet
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) quiet_q <= 0;
      else quiet_q <= receiver_packet_stb ? 0 : quiet_q + 1;
   end
   a_ready_after_setup: assert property (setup |=> pready)
      else $error("no ready");
   a_misaligned_err: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
      else $error("no error");
   a_ro_no_err: assert property (setup && paddr >= 12'h154 && paddr <= 12'h178 && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("ro error");
   a_offset_write: assert property (setup && pwrite && paddr == 12'h060 && pstrb == 4'hf ##1 pready |=> magnetic_offset_x == $past(pwdata))
      else $error("offset lost");
   a_offset_hold: assert property (!(psel && pwrite) |=> $stable(magnetic_offset_x))
      else $error("offset moved");
   a_bad_write_drop: assert property (setup && pwrite && paddr[1:0] != 2'h0 |=> ##1 $stable(magnetic_offset_x))
      else $error("error write landed");
   a_pkt_clears: assert property (receiver_packet_stb |=> !receiver_timeout_flag)
      else $error("flag kept");
   a_timeout_early: assert property ($rose(receiver_timeout_flag) |-> quiet_q >= RXTO_LIMIT - 2)
      else $error("early");
   a_timeout_late: assert property (quiet_q >= RXTO_LIMIT + 3 |-> receiver_timeout_flag)
      else $error("late");
   cover property (setup && pwrite);
   cover property ($rose(receiver_timeout_flag));
   cover property (receiver_packet_stb && receiver_timeout_flag);
endmodule

// file: bench/ahrs_health_raw_sensor_regs_tb.sv
// Testbench: offsets, health word, raw samples and receiver timeout
`timescale 1ns/1ps
module ahrs_health_raw_sensor_regs_tb;
   import ahrs_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fix = 0, pkt = 0, pready, pslverr, e, tof;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic [5:0] used = 0, vis = 0, flg = 0;
   logic [9:0] prec = 0;
   logic [2:0] fire = 0;
   wire [2:0] stb;
   logic [3:0] strb = 4'hf;
   logic [15:0] pat [3] = '{16'h8000, 16'h7fff, 16'hfffe};
   logic [15:0] sx [3], sy [3], sz [3];
   logic [31:0] st [3], offs [3];
   int num_errors = 0, samples_checked = 0, cycles = 0;
   ahrs_regs #(.RXTO_LIMIT(50)) i_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .satellites_used_count(used), .horizontal_precision_field(prec),
      .satellites_visible_count(vis), .receiver_fix_valid(fix), .receiver_packet_stb(pkt),
      .tx_rate_overrun_flag(flg[5]), .field_norm_fault_flag(flg[4]), .gravity_norm_fault_flag(flg[3]),
      .accel_init_fail(flg[2]), .rate_init_fail(flg[1]), .field_init_fail(flg[0]), .rate_sample_stb(stb[0]),
      .rate_x(sx[0]), .rate_y(sy[0]), .rate_z(sz[0]), .rate_time(st[0]), .accel_sample_stb(stb[1]),
      .accel_x(sx[1]), .accel_y(sy[1]), .accel_z(sz[1]), .accel_time(st[1]), .field_sample_stb(stb[2]),
      .field_x(sx[2]), .field_y(sy[2]), .field_z(sz[2]), .field_time(st[2]), .magnetic_offset_x(offs[0]),
      .magnetic_offset_y(offs[1]), .magnetic_offset_z(offs[2]), .receiver_timeout_flag(tof));
   // One front-end model per sensor
   for (genvar k = 0; k < 3; k++) begin : g_sen
      ahrs_sensor_model i_sen(.pclk(pclk), .fire(fire[k]), .pat(pat[k]), .stb(stb[k]), .x(sx[k]), .y(sy[k]),
         .z(sz[k]), .t(st[k]));
   end
   always #5 pclk = ~pclk;
   // Cut a hang short
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         wrap_up();
      end
   end
   function automatic logic [11:0] addr(input logic [7:0] i);
      return {2'b00, i, 2'b00};
   endfunction
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", n, x, g);
      end
   endtask
   // Setup, then access held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(0, a, 32'h0);
      chk("read data", x, r);
   endtask
   task automatic t_offsets;
      for (int k = 0; k < 3; k++) begin
         rd(addr(IDX_MAG_OFF_X + 8'(k)), 32'h0);
         apb(1, addr(IDX_MAG_OFF_X + 8'(k)), {24'h3f8000, 8'(k)});
         rd(addr(IDX_MAG_OFF_X + 8'(k)), {24'h3f8000, 8'(k)});
         chk("offset", {24'h3f8000, 8'(k)}, offs[k]);
      end
      strb <= 4'h2;
      apb(1, addr(IDX_MAG_OFF_X), 32'haaaa_aaaa);
      strb <= 4'hf;
      rd(addr(IDX_MAG_OFF_X), 32'h3f80_aa00);
   endtask
   // Second pass drops the fix: receiver fields hold, flags clear
   task automatic t_health;
      for (int i = 0; i < 2; i++) begin
         fix <= (i == 0);
         used <= (i == 0) ? 6'h3f : 6'h00;
         prec <= 10'h3e7;
         vis <= 6'h15;
         flg <= (i == 0) ? 6'h3f : 6'h00;
         pkt <= 1;
         @(posedge pclk);
         pkt <= 0;
         apb(1, addr(IDX_HEALTH), 32'h0);
         rd(addr(IDX_HEALTH), (i == 0) ? 32'hffe7_553e : 32'hffe7_5400);
      end
   endtask
   task automatic t_raw;
      fire <= 3'b111;
      @(posedge pclk);
      fire <= 3'b000;
      repeat (3) @(posedge pclk);
      for (int k = 0; k < 3; k++) begin
         apb(1, addr(IDX_RATE_XY + 8'(3 * k)), 32'hffff_ffff);
         rd(addr(IDX_RATE_XY + 8'(3 * k)), {pat[k], ~pat[k]});
         rd(addr(IDX_RATE_Z + 8'(3 * k)), {pat[k] ^ 16'h8001, 16'h0});
         rd(addr(IDX_RATE_TIME + 8'(3 * k)), {~pat[k], pat[k]});
      end
   endtask
   task automatic t_timeout;
      repeat (60) @(posedge pclk);
      chk("timeout", 32'h1, {31'h0, tof});
      rd(addr(IDX_HEALTH), 32'hffe7_5401);
      pkt <= 1;
      @(posedge pclk);
      pkt <= 0;
      repeat (2) @(posedge pclk);
      chk("timeout", 32'h0, {31'h0, tof});
      apb(0, 12'h000, 32'h0);
      chk("unmapped", 32'h1, {31'h0, e});
      apb(1, 12'h061, 32'hdead_beef);
      chk("misaligned", 32'h1, {31'h0, e});
      chk("offset", 32'h3f80_aa00, offs[0]);
      apb(0, 12'h460, 32'h0);
      chk("alias error", 32'h1, {31'h0, e});
      chk("alias data", 32'h0, r);
   endtask
   task automatic wrap_up;
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      t_offsets();
      t_health();
      t_raw();
      t_timeout();
      wrap_up();
   end
endmodule
bind ahrs_regs ahrs_regs_sva #(.RXTO_LIMIT(RXTO_LIMIT)) u_sva(.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
   .pslverr(pslverr), .receiver_packet_stb(receiver_packet_stb), .magnetic_offset_x(magnetic_offset_x),
   .receiver_timeout_flag(receiver_timeout_flag));
